/* File: common/rstctl_pkg.sv */
// Constants, encodings and carriers shared by the reset and sleep controller.
package rstctl_pkg;

  // Clock and time base.
  localparam int CLK_PERIOD_NS = 100;
  localparam int CLK_MHZ = 10;

  // Least low time on the external reset pin, rounded up to cycles.
  localparam int EXT_MIN_PULSE_NS = 2500;
  localparam int EXT_MIN_CYCLES_I =
    (EXT_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] EXT_MIN_CYCLES = 5'(EXT_MIN_CYCLES_I);

  // Reset stretch periods chosen by the startup fuses.
  localparam int TOUT_MIN_CYCLES_I = 6;
  localparam int TOUT_FAST_US = 4100;
  localparam int TOUT_SLOW_US = 65000;
  localparam int TOUT_FAST_CYCLES = TOUT_FAST_US * CLK_MHZ;
  localparam int TOUT_SLOW_CYCLES = TOUT_SLOW_US * CLK_MHZ;
  localparam int CNT_W = 20;
  localparam logic [CNT_W-1:0] TOUT_MIN_CYCLES = 20'(TOUT_MIN_CYCLES_I);

  // Register offsets on the APB slave.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_DIS0 = 8'h08;
  localparam logic [7:0] ADDR_DIS1 = 8'h0c;
  localparam logic [7:0] ADDR_STATE = 8'h10;

  // Field positions and reset values.
  localparam int CTRL_SCAN_DIS_BIT = 0;
  localparam logic [4:0] FLAGS_RESET = 5'h01;
  localparam logic [4:0] FLAGS_POR = 5'h01;
  localparam logic [7:0] DIS_RESET = 8'h00;
  localparam logic CTRL_RESET = 1'b0;

  // Brown-out level fuse code that leaves the detector off.
  localparam logic [2:0] BROWNOUT_OFF_CODE = 3'h7;

  // Sleep mode codes that stop the main clock.
  localparam logic [2:0] SLEEP_PDOWN = 3'h2;
  localparam logic [2:0] SLEEP_PSAVE = 3'h3;

  // Reset sequencer states, one-hot.
  typedef enum logic [2:0] {
    S_HOLD = 3'b001,
    S_STRETCH = 3'b010,
    S_RUN = 3'b100
  } rst_state_e;

  // One bit per reset source; also the layout of the flag register.
  typedef struct packed {
    logic scan;
    logic watchdog;
    logic brownout;
    logic external;
    logic poweron;
  } src_s;

  // Power and enable controls sent to the rest of the chip.
  typedef struct packed {
    logic brownout_enable;
    logic watchdog_run;
    logic vref_enable;
    logic main_clock_keep;
    logic scan_port_enabled;
  } pwr_s;

endpackage : rstctl_pkg

/* File: dv/reset_and_sleep_power_control_bench.sv */
// Self-checking bench for the reset combiner and sleep power controls.
`timescale 1ns/1ps
module reset_and_sleep_power_control_bench;
  import rstctl_pkg::*;

  // One table row: power inputs beside the controls that they should give.
  typedef struct packed {
    logic [2:0] bo;
    logic wde, cmp, adc, slp;
    logic [2:0] mode;
    logic ios, adcs, dbg, scf;
    logic [4:0] pw;
    logic gate;
  } row_s;

  logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, err, sys_reset, io_reset_async, cpu_start;
  logic tdo_out, tdo_oe_n;
  logic pon = 1'b1, ext_n = 1'b1, bo_low = 1'b0, wde = 1'b0, wdt = 1'b0;
  logic scan = 1'b0, dbg = 1'b0, scf = 1'b0, cmp = 1'b0, adc = 1'b0;
  logic slp = 1'b0, ios = 1'b0, adcs = 1'b0, tsh = 1'b0, ttdo = 1'b0;
  logic [2:0] bo = 3'h7, mode = 3'h0;
  logic [1:0] st_fuse = 2'h0;
  logic [3:0] cks = 4'h0;
  logic ce = 1'b1;
  pwr_s pwr;
  logic [15:0] ibuf;
  int mismatches = 0, n_checks = 0, hi, starts;
  int hold [5] = '{8, 40, 8, 1, 8};
  int slack [5] = '{8, 8, 8, 3, 3};
  row_s rows [10] = '{
    '{3'h7,0,0,0,0,3'h0,0,0,0,0,5'h00,0}, '{3'h6,0,0,0,0,3'h0,0,0,0,0,5'h14,0},
    '{3'h7,1,0,0,1,3'h2,1,1,0,0,5'h08,1}, '{3'h7,0,1,0,0,3'h0,0,0,0,0,5'h04,0},
    '{3'h7,0,0,1,1,3'h0,1,0,0,0,5'h04,0}, '{3'h7,0,0,0,1,3'h2,0,0,1,1,5'h03,0},
    '{3'h7,0,0,0,1,3'h3,1,1,1,1,5'h03,1}, '{3'h7,0,0,0,1,3'h1,0,0,1,1,5'h01,0},
    '{3'h7,0,0,0,0,3'h2,0,0,1,1,5'h01,0}, '{3'h5,1,0,0,1,3'h2,0,0,0,1,5'h1d,0}};

  // Short stretch lengths keep the run brief; expectations use these values.
  reset_power_ctl #(.TOUT_FAST(20'h14), .TOUT_SLOW(20'h28)) u_dut (
    .mclk(mclk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .poweron_low(pon),
    .ext_reset_n(ext_n), .brownout_low(bo_low), .watchdog_enable(wde),
    .watchdog_timeout(wdt), .scan_reset_bit(scan),
    .brownout_level_fuses(bo), .startup_time_fuses(st_fuse),
    .clock_select_fuses(cks), .debug_enable_fuse(dbg),
    .scan_port_enable_fuse(scf), .comparator_uses_ref(cmp),
    .adc_enable(adc), .sleep_active(slp), .sleep_mode(mode),
    .io_clk_stopped(ios), .adc_clk_stopped(adcs),
    .wake_pin_keep(16'h0081), .tap_shifting(tsh), .tap_tdo(ttdo),
    .sys_reset(sys_reset), .io_reset_async(io_reset_async),
    .cpu_start(cpu_start), .pwr(pwr), .input_buffer_disable(ibuf),
    .tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n));

  // Clock at 10 MHz.
  initial forever #50 mclk = ~mclk;

  task check(input logic [31:0] seen, input logic [31:0] exp, input string s);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t %s seen %h expected %h", $time, s, seen, exp);
    end
  endtask : check

  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  // APB transfer; the request is held until pready is seen at an edge.
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Only the bench watchdog ends a wait that never sees pready.
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task set_src(input int i, input logic v);
    case (i)
      0: pon <= v;
      1: ext_n <= ~v;
      2: bo_low <= v;
      3: wdt <= v;
      default: scan <= v;
    endcase
  endtask : set_src

  // Pulses one source, then counts reset-high cycles and start pulses.
  task src_test(input int i, input int h, input logic r, input int t,
                input int sl);
    @(posedge mclk);
    set_src(i, 1'b1);
    #1;
    if (r && i < 3) check(32'(io_reset_async), 32'h1, "port reset");
    repeat (h) @(posedge mclk);
    set_src(i, 1'b0);
    hi = 0;
    starts = 0;
    repeat (80) begin
      @(posedge mclk);
      hi += int'(sys_reset === 1'b1);
      starts += int'(cpu_start === 1'b1);
    end
    check(32'(hi >= t && hi <= t + sl), 32'(r), "stretch");
    check(32'(starts), 32'(r), "start pulse");
  endtask : src_test

  // Watchdog cuts a hang short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    $display("ERROR %0t run did not finish", $time);
    finish_test();
  end

  initial begin
    repeat (2) @(posedge mclk);
    check(32'({sys_reset, io_reset_async, tdo_oe_n}), 32'h7, "in rst");
    check(32'(pwr), 32'h0, "pwr in rst");
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    pon <= 1'b0;
    repeat (40) @(posedge mclk);
    check(32'(sys_reset), 32'h0, "startup");
    apb(1'b0, ADDR_FLAGS, 32'h0);
    check(q, 32'h1, "por flag");
    check(32'(err), 32'h0, "mapped access");
    foreach (hold[k]) begin
      apb(1'b0, 8'(k * 4), 32'h0);
      if (k != 1)
        check(q, k == 4 ? 32'(S_RUN) << 1 : 32'h0, "reg reset");
    end
    apb(1'b0, 8'h14, 32'h0);
    check({q[30:0], err}, 32'h1, "unmapped");
    // Power controls across fuses, users and sleep modes.
    foreach (rows[k]) begin
      @(posedge mclk);
      {bo, wde, cmp, adc, slp, mode, ios, adcs, dbg, scf} <= rows[k][19:6];
      repeat (2) @(posedge mclk);
      check(32'(pwr), 32'(rows[k].pw), "pwr");
      check(32'(ibuf), rows[k].gate ? 32'hff7e : 32'h0, "gating");
    end
    {slp, dbg, scf, bo, wde} <= {1'b0, 1'b0, 1'b1, 3'h6, 1'b1};
    apb(1'b1, ADDR_DIS0, 32'ha5);
    apb(1'b1, ADDR_DIS1, 32'h3c);
    repeat (2) @(posedge mclk);
    check(32'(ibuf), 32'h3ca5, "buffer disable");
    apb(1'b1, ADDR_CTRL, 32'h1);
    repeat (2) @(posedge mclk);
    check(32'(pwr.scan_port_enabled), 32'h0, "scan off");
    tsh <= 1'b1;
    ttdo <= 1'b1;
    repeat (2) @(posedge mclk);
    check(32'(tdo_oe_n), 32'h1, "tdo while disabled");
    apb(1'b1, ADDR_CTRL, 32'h0);
    repeat (2) @(posedge mclk);
    check(32'({tdo_oe_n, tdo_out}), 32'h1, "tdo drive");
    tsh <= 1'b0;
    repeat (2) @(posedge mclk);
    check(32'(tdo_oe_n), 32'h1, "tdo float");
    // Every source in turn; each leaves only its own flag.
    foreach (hold[i]) begin
      apb(1'b1, ADDR_FLAGS, 32'h0);
      src_test(i, hold[i], 1'b1, 6, slack[i]);
      apb(1'b0, ADDR_FLAGS, 32'h0);
      check(q, 32'h1 << i, "flags");
    end
    apb(1'b0, ADDR_DIS0, 32'h0);
    check(q, 32'h0, "reset clears");
    apb(1'b1, ADDR_FLAGS, 32'h0);
    src_test(1, 10, 1'b0, 6, 8);
    wde <= 1'b0;
    src_test(3, 1, 1'b0, 6, 3);
    bo <= 3'h7;
    wde <= 1'b1;
    src_test(2, 8, 1'b0, 6, 8);
    apb(1'b0, ADDR_FLAGS, 32'h0);
    check(q, 32'h0, "no flags");
    // A source returning mid-stretch restarts the count.
    scan <= 1'b1;
    repeat (3) @(posedge mclk);
    scan <= 1'b0;
    repeat (3) @(posedge mclk);
    src_test(4, 3, 1'b1, 6, 3);
    src_test(3, 1, 1'b1, 6, 3);
    apb(1'b1, ADDR_FLAGS, 32'h8);
    apb(1'b0, ADDR_FLAGS, 32'h0);
    check(q, 32'h8, "flag keep");
    st_fuse <= 2'h1;
    src_test(4, 3, 1'b1, 20, 3);
    st_fuse <= 2'h2;
    src_test(4, 3, 1'b1, 40, 3);
    st_fuse <= 2'h0;
    cks <= 4'h8;
    src_test(4, 3, 1'b1, 40, 3);
    cks <= 4'h0;
    // A reset in mid-run drops written registers to their defaults.
    apb(1'b1, ADDR_DIS0, 32'h5a);
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    check(32'({sys_reset, ibuf}), 32'h10000, "mid reset");
    rst <= 1'b0;
    repeat (40) @(posedge mclk);
    check(32'(sys_reset), 32'h0, "restart");
    apb(1'b0, ADDR_DIS0, 32'h0);
    check(q, 32'h0, "dis after reset");
    apb(1'b0, ADDR_FLAGS, 32'h0);
    check(q, 32'(FLAGS_POR), "flags after reset");
    // Clock enable low freezes the sequencer although a source is active.
    ce <= 1'b0;
    scan <= 1'b1;
    repeat (4) @(posedge mclk);
    check(32'(sys_reset), 32'h0, "frozen");
    scan <= 1'b0;
    ce <= 1'b1;
    repeat (4) @(posedge mclk);
    check(32'(sys_reset), 32'h0, "no late reset");
    finish_test();
  end
endmodule : reset_and_sleep_power_control_bench

/* File: rtl/level_sync3.sv */
// Three-stage synchroniser with agreement check for asynchronous levels.
`timescale 1ns/1ps
module level_sync3 #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic async_in,
  output logic sync_out
);

  logic meta;
  logic s2;
  logic s3;

  // The output moves only when stages two and three agree, so a single
  // resolved glitch from the first stage never reaches the user.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta <= RESET_VAL;
      s2 <= RESET_VAL;
      s3 <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else if (ce) begin
      meta <= async_in;
      s2 <= meta;
      s3 <= s2;
      if (s2 == s3) begin
        sync_out <= s3;
      end
    end
  end

endmodule : level_sync3

/* File: rtl/reset_power_ctl.sv */
// Reset combiner, reset stretcher and sleep power controls with APB access.
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
// How it works
// - Reset returns control registers to defaults; release pulses cpu_start.
// - Port reset output follows raw power-on, pin, brown-out and scan levels with no clock needed; watchdog enters through its registered pulse.
// - Internal reset stays high for a fuse-selected count after sources clear.
// - Exactly five sources: power-on, pin, watchdog, brown-out, scan register.
// - Reset held while the power-on detector reports low supply.
// - Pin reset only after the pin stays low the minimum pulse length.
// - Watchdog timeout causes reset only while the watchdog is enabled.
// - Brown-out causes reset only while the detector is fuse-enabled.
// - Reset held while the scan-chain reset bit is one.
// - Brown-out detector stays enabled in every sleep mode when fused on.
// - Enabled watchdog keeps running in every sleep mode.
// - Reference on only while brown-out, comparator or converter need it.
// - In sleep with both I/O and converter clocks stopped: buffers off except wake pins.
// - Software disables single input buffers through two disable registers.
// - Debug fuse keeps main clock running in power-down and power-save while the scan port is enabled.
// - Scan port off when disable bit is one or enable fuse unprogrammed.
// - TDO undriven while scan port enabled but not shifting.
// - Watchdog reset is a one-cycle pulse; stretch starts one cycle after it falls.
// - Watchdog flag set on watchdog reset, cleared by power-on or zero write.
module reset_power_ctl
  import rstctl_pkg::*;
#(
  parameter logic [CNT_W-1:0] TOUT_FAST = 20'(TOUT_FAST_CYCLES),
  parameter logic [CNT_W-1:0] TOUT_SLOW = 20'(TOUT_SLOW_CYCLES)
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic poweron_low,
  input wire logic ext_reset_n,
  input wire logic brownout_low,
  input wire logic watchdog_enable,
  input wire logic watchdog_timeout,
  input wire logic scan_reset_bit,
  input wire logic [2:0] brownout_level_fuses,
  input wire logic [1:0] startup_time_fuses,
  input wire logic [3:0] clock_select_fuses,
  input wire logic debug_enable_fuse,
  input wire logic scan_port_enable_fuse,
  input wire logic comparator_uses_ref,
  input wire logic adc_enable,
  input wire logic sleep_active,
  input wire logic [2:0] sleep_mode,
  input wire logic io_clk_stopped,
  input wire logic adc_clk_stopped,
  input wire logic [15:0] wake_pin_keep,
  input wire logic tap_shifting,
  input wire logic tap_tdo,
  output logic sys_reset,
  output logic io_reset_async,
  output logic cpu_start,
  output rstctl_pkg::pwr_s pwr,
  output logic [15:0] input_buffer_disable,
  output logic tdo_out,
  output logic tdo_oe_n
);
  import rstctl_pkg::*;

  // Stretch length from the startup and clock-select fuses.
  function automatic logic [CNT_W-1:0] tout_target(
    input logic [1:0] stime,
    input logic [3:0] csel
  );
    logic [CNT_W-1:0] t;
    t = TOUT_MIN_CYCLES;
    if (stime == 2'h1) begin
      t = TOUT_FAST;
    end else if (stime[1] || csel[3]) begin
      t = TOUT_SLOW;
    end
    return t;
  endfunction : tout_target

  logic por_sync;
  logic ext_low_sync;
  logic brownout_low_sync;
  logic [4:0] ext_cnt;
  logic wdt_pulse;
  src_s src;
  src_s flags;
  src_s next_flags;
  logic src_any;
  rst_state_e state;
  rst_state_e next_state;
  logic [CNT_W-1:0] stretch_cnt;
  logic [CNT_W-1:0] target;
  logic stretch_done;
  logic scan_dis;
  logic [7:0] dis0;
  logic [7:0] dis1;
  logic brownout_on;
  logic scan_en;
  pwr_s next_pwr;
  logic [15:0] next_ibuf;
  logic wr_en;
  logic rd_setup;
  logic hit;
  logic [31:0] rd_mux;

  // Asynchronous detector and pin levels pass a three-stage synchroniser.
  level_sync3 #(.RESET_VAL(1'b1)) u_por_sync (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .async_in(poweron_low),
    .sync_out(por_sync)
  );

  level_sync3 #(.RESET_VAL(1'b0)) u_ext_sync (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .async_in(~ext_reset_n),
    .sync_out(ext_low_sync)
  );

  level_sync3 #(.RESET_VAL(1'b0)) u_brownout_sync (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .async_in(brownout_low),
    .sync_out(brownout_low_sync)
  );

  // Source requests, one per documented cause.
  assign brownout_on = (brownout_level_fuses != BROWNOUT_OFF_CODE);
  assign src.poweron = por_sync;
  assign src.external = ext_low_sync && (ext_cnt == EXT_MIN_CYCLES);
  assign src.watchdog = wdt_pulse;
  assign src.brownout = brownout_low_sync && brownout_on;
  assign src.scan = scan_reset_bit;
  assign src_any = |src;

  // Port reset works from the raw power-on, pin, brown-out and scan levels with no clock; the watchdog enters via the clocked wdt_pulse.
  // Short pin glitches can reach it; the stretched reset filters them.
  assign io_reset_async = poweron_low | ~ext_reset_n | wdt_pulse |
    (brownout_low & brownout_on) | scan_reset_bit | sys_reset;

  // Pin low-time filter saturates at the minimum pulse length.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ext_cnt <= 5'h00;
    end else if (ce) begin
      if (!ext_low_sync) begin
        ext_cnt <= 5'h00;
      end else if (ext_cnt != EXT_MIN_CYCLES) begin
        ext_cnt <= ext_cnt + 5'h01;
      end
    end
  end

  // Watchdog request is cut to a single cycle; the stretch then starts
  // one cycle after the pulse's falling edge, once the sequencer samples it low.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wdt_pulse <= 1'b0;
    end else if (ce) begin
      wdt_pulse <= watchdog_timeout && watchdog_enable && !wdt_pulse;
    end
  end

  // Sequencer: hold while any source is active, then stretch, then run.
  assign target = tout_target(startup_time_fuses, clock_select_fuses);
  assign stretch_done = (stretch_cnt == target - 20'h00001);

  always_comb begin
    next_state = state;
    case (state)
      S_HOLD: begin
        if (!src_any) begin
          next_state = S_STRETCH;
        end
      end
      S_STRETCH: begin
        if (src_any) begin
          next_state = S_HOLD;
        end else if (stretch_done) begin
          next_state = S_RUN;
        end
      end
      S_RUN: begin
        if (src_any) begin
          next_state = S_HOLD;
        end
      end
      default: begin
        next_state = S_HOLD;
      end
    endcase
  end

  // The stretch counter only runs in the stretch state and is cleared
  // everywhere else, so a reasserted source always restarts from zero.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= S_HOLD;
      stretch_cnt <= '0;
      sys_reset <= 1'b1;
      cpu_start <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      if (next_state == S_STRETCH && state == S_STRETCH) begin
        stretch_cnt <= stretch_cnt + 20'h00001;
      end else begin
        stretch_cnt <= '0;
      end
      sys_reset <= (next_state != S_RUN);
      cpu_start <= (next_state == S_RUN) && (state == S_STRETCH);
    end
  end

  // Flags: set wins over a software clear; power-on clears the others.
  always_comb begin
    next_flags = flags;
    if (wr_en && paddr == ADDR_FLAGS) begin
      next_flags = flags & src_s'(pwdata[4:0]);
    end
    if (src.poweron) begin
      next_flags = src_s'(FLAGS_POR);
    end
    next_flags = next_flags | src;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flags <= src_s'(FLAGS_RESET);
    end else if (ce) begin
      flags <= next_flags;
    end
  end

  // APB slave: zero wait states, error on unmapped addresses.
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign pready = 1'b1;
  assign hit = (paddr == ADDR_CTRL) || (paddr == ADDR_FLAGS) ||
    (paddr == ADDR_DIS0) || (paddr == ADDR_DIS1) || (paddr == ADDR_STATE);
  assign pslverr = psel && penable && !hit;
  assign rd_mux =
    (paddr == ADDR_CTRL) ? {31'h0, scan_dis} :
    (paddr == ADDR_FLAGS) ? {27'h0, flags} :
    (paddr == ADDR_DIS0) ? {24'h0, dis0} :
    (paddr == ADDR_DIS1) ? {24'h0, dis1} :
    (paddr == ADDR_STATE) ? {27'h0, scan_en, state, sys_reset} :
    32'h0;

  // Read data is captured in the setup cycle and stands for the access.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0;
    end else if (ce && rd_setup) begin
      prdata <= rd_mux;
    end
  end

  // Control registers fall back to their defaults while reset is held.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      scan_dis <= CTRL_RESET;
      dis0 <= DIS_RESET;
      dis1 <= DIS_RESET;
    end else if (ce) begin
      if (sys_reset) begin
        scan_dis <= CTRL_RESET;
        dis0 <= DIS_RESET;
        dis1 <= DIS_RESET;
      end else if (wr_en && paddr == ADDR_CTRL) begin
        scan_dis <= pwdata[CTRL_SCAN_DIS_BIT];
      end else if (wr_en && paddr == ADDR_DIS0) begin
        dis0 <= pwdata[7:0];
      end else if (wr_en && paddr == ADDR_DIS1) begin
        dis1 <= pwdata[7:0];
      end
    end
  end

  // Power controls. The detector and watchdog ignore the sleep state by
  // design: leaving them on costs current but keeps protection in sleep.
  assign scan_en = scan_port_enable_fuse && !scan_dis;
  assign next_pwr.brownout_enable = brownout_on;
  assign next_pwr.watchdog_run = watchdog_enable;
  assign next_pwr.vref_enable = brownout_on || comparator_uses_ref ||
    adc_enable;
  assign next_pwr.main_clock_keep = debug_enable_fuse && scan_en &&
    sleep_active && (sleep_mode == SLEEP_PDOWN ||
    sleep_mode == SLEEP_PSAVE);
  assign next_pwr.scan_port_enabled = scan_en;
  assign next_ibuf = {dis1, dis0} |
    ((sleep_active && io_clk_stopped && adc_clk_stopped) ?
    ~wake_pin_keep : 16'h0000);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pwr <= '0;
      input_buffer_disable <= 16'h0000;
      tdo_out <= 1'b0;
      tdo_oe_n <= 1'b1;
    end else if (ce) begin
      pwr <= next_pwr;
      input_buffer_disable <= next_ibuf;
      tdo_out <= tap_tdo;
      tdo_oe_n <= !(scan_en && tap_shifting);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_src_to_reset: assert property (
    (ce && src_any) |=> sys_reset)
    else $error("Active source did not hold internal reset.");

  a_stretch_length: assert property (
    (ce && $fell(sys_reset)) |->
    $past(stretch_cnt) == $past(target) - 20'h00001)
    else $error("Reset released before the stretch count ended.");

  a_restart_zero: assert property (
    (ce && state == S_STRETCH && src_any) |=> stretch_cnt == '0)
    else $error("Stretch count not restarted on reasserted source.");

  a_wdt_one_cycle: assert property (
    (ce && wdt_pulse) |=> !wdt_pulse)
    else $error("Watchdog reset pulse longer than one cycle.");

  a_wdt_flag_set: assert property (
    (ce && wdt_pulse) |=> flags.watchdog)
    else $error("Watchdog flag not set by watchdog reset.");

  a_ext_min_low: assert property (
    src.external |-> $past(ext_low_sync, EXT_MIN_CYCLES_I))
    else $error("Pin reset taken without a held low level.");

  a_port_reset: assert property (
    (poweron_low || !ext_reset_n || scan_reset_bit) |-> io_reset_async)
    else $error("Port reset missing while a raw source is active.");

  a_vref_need: assert property (
    (ce && !brownout_on && !comparator_uses_ref && !adc_enable)
    |=> !pwr.vref_enable)
    else $error("Reference left on with no user.");

  a_tdo_float: assert property (
    (ce && scan_en && !tap_shifting) |=> tdo_oe_n)
    else $error("TDO driven while not shifting.");

  a_clock_keep: assert property (
    (ce && !scan_en) |=> !pwr.main_clock_keep)
    else $error("Main clock kept with the scan port disabled.");

  a_ibuf_gate: assert property (
    (ce && sleep_active && io_clk_stopped && adc_clk_stopped)
    |=> (input_buffer_disable | $past(wake_pin_keep)) == 16'hffff)
    else $error("Input buffers left on with both clocks stopped.");

endmodule : reset_power_ctl
